/* File: nppc_core.sv */
// Nonvolatile memory programming sequencer, protect logic and register slave
`timescale 1ns/1ns
// Behaviour
// - One-time latch select set: memory writes with its voltage off latch address and data, reads blocked.
// - One-time latch select always readable; writes ignored while its voltage is on.
// - Extra columns: user array off, address bits 13:5 used, 4:0 ignored.
// - Extra columns select accessible only in special modes, else reads zero.
// - Extra rows: two rows, address bits 7:0 used; special modes only.
// - Two-bit stress field, special modes only, reads zero in normal modes.
// - One-time voltage enable always readable, writable only with latch select set.
// - Bit 6 of the one-time control register always reads zero.
// - Erased cell reads one; programming only turns ones into zeros.
// - Erasable latch select clear: erasable memory reads like read-only memory.
// - Control register always accessible; sequencing stops stray writes changing data.
// - Pump clock is system clock when select is zero, RC oscillator when one.
// - Voltage only after latch write, then valid memory write, then both bits set.
// - One write from idle setting both latch select and voltage enable leaves both clear.
// - Protect bits reset to one; normal modes clear them only in first 64 cycles.
// - Writing one to a protect bit is accepted at any time.
// - In special modes protect bits may be cleared at any time.
// - Erasable memory is mapped only while the visible bit of setup word is set.
// - Setup word protect bit set blocks programming and erasing the setup word.
// - Four block bits guard 32, 64, 128 and 288 byte blocks in order.
// - Large array: four 512-byte blocks, upper nibble from the base field.
// - Protect register bits 7:5 always read zero.
// - Byte bit erases one byte; else row bit erases 16 bytes, or whole array.
// - Erase bit zero means read or program, one means erase.
// - Erasable latch select set: array paths serve programming, array unreadable.
module nppc_core
	import nppc_pkg::*;
#(
	parameter bit         LARGE_ARRAY = 1'b0,
	parameter logic [7:0] SETUP_INIT  = 8'h01
) (
	input  wire logic                clk_sys_i,
	input  wire logic                sys_rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [nppc_pkg::WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                special_mode_i,
	input  wire logic                mem_we_i,
	input  wire logic                mem_re_i,
	input  wire logic [15:0]         mem_addr_i,
	input  wire logic [7:0]          mem_wdata_i,
	output logic      [7:0]          ee_rdata_o,
	output logic                     ee_hit_o,
	output logic      [15:0]         otp_latched_addr_o,
	output logic      [7:0]          otp_latched_data_o,
	output logic      [13:0]         otp_array_addr_o,
	output logic                     otp_read_enable_o,
	output logic                     otp_voltage_o,
	output logic      [1:0]          otp_stress_o,
	output logic                     ee_voltage_o,
	input  wire logic                rc_osc_clk_i,
	output logic                     pump_clk_o
);

	localparam int DEPTH = LARGE_ARRAY ? LARGE_DEPTH : SMALL_DEPTH;
	localparam int AW    = $clog2(DEPTH);

	// Block decode and base field only cover arrays up to 2048 bytes
	if (AW > 11) begin : g_depth_check
		$error("nppc_core: array depth not supported");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0]   mem_ff [DEPTH] = '{default: ERASED_BYTE};
	logic [7:0]   setup_ff = SETUP_INIT;
	logic [7:0]   prot_ff;
	logic [6:0]   win_cnt_ff;
	nppc_seq_type seq_ff;
	nppc_seq_type nxt_seq;
	logic [6:2]   ee_mode_ff;
	logic [15:0]  ee_addr_ff;
	logic [7:0]   ee_data_ff;
	logic         otp_latch_ff;
	logic         otp_volt_ff;
	logic         xcols_ff;
	logic         xrows_ff;
	logic [1:0]   stress_ff;
	logic         pump_sel_ff;
	logic         ack_ff;
	logic [31:0]  rdat_ff;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire logic req       = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire logic wr        = req & wb_we_i & wb_sel_i[0];
	wire logic [7:0] wd  = wb_dat_i[7:0];
	wire logic wr_nvm    = wr & (wb_adr_i == ADR_NVM_CTRL);
	wire logic wr_otp    = wr & (wb_adr_i == ADR_OTP_CTRL);
	wire logic wr_prot   = wr & (wb_adr_i == ADR_BLOCK_PROT);
	wire logic wr_option = wr & (wb_adr_i == ADR_OPTION);

	// ****************************************************************
	// Memory map and protection
	// ****************************************************************
	wire logic        visible  = setup_ff[POS_MEM_VISIBLE];
	wire logic [15:0] ee_base  = LARGE_ARRAY ? {setup_ff[POS_BASE_LO+:4], LARGE_OFFSET} : SMALL_BASE;
	wire logic [15:0] mem_off  = mem_addr_i - ee_base;
	wire logic        in_array = visible & (mem_addr_i >= ee_base) & (mem_off < 16'(DEPTH));
	wire logic        is_setup = (mem_addr_i == MEM_SETUP_ADDR);
	wire logic [15:0] lat_off  = ee_addr_ff - ee_base;
	wire logic        lat_set  = (ee_addr_ff == MEM_SETUP_ADDR);
	wire logic        special  = special_mode_i;
	wire logic        win_open = (win_cnt_ff < 7'(PROT_WINDOW_CYC));

	function automatic logic [1:0] blk_of(input logic [15:0] off);
		if (LARGE_ARRAY)
			blk_of = off[10:9];
		else if (off < BLK1_START)
			blk_of = 2'd0;
		else if (off < BLK2_START)
			blk_of = 2'd1;
		else if (off < BLK3_START)
			blk_of = 2'd2;
		else
			blk_of = 2'd3;
	endfunction

	wire logic lat_blocked = lat_set ? prot_ff[POS_SETUP_PROT] : prot_ff[blk_of(lat_off)];

	// ****************************************************************
	// Erasable sequencer
	// ****************************************************************
	wire logic wr_l      = wd[POS_LATCH];
	wire logic wr_p      = wd[POS_VOLT];
	wire logic mem_capt  = mem_we_i & (in_array | is_setup) & ((seq_ff == SEQ_OPEN) | (seq_ff == SEQ_LOADED));
	wire logic op_go     = (seq_ff == SEQ_LOADED) & (nxt_seq == SEQ_HIGH_VOLT) & ~lat_blocked;
	wire logic erase_op  = ee_mode_ff[POS_ERASE];

	always_comb begin
		nxt_seq = seq_ff;
		if (wr_nvm) begin
			unique case (seq_ff)
				SEQ_IDLE:      nxt_seq = (wr_l & ~wr_p) ? SEQ_OPEN : SEQ_IDLE;
				SEQ_OPEN:      nxt_seq = wr_l ? SEQ_OPEN : SEQ_IDLE;
				SEQ_LOADED:    nxt_seq = ~wr_l ? SEQ_IDLE : (wr_p ? SEQ_HIGH_VOLT : SEQ_LOADED);
				SEQ_HIGH_VOLT: nxt_seq = ~wr_l ? SEQ_IDLE : (wr_p ? SEQ_HIGH_VOLT : SEQ_LOADED);
			endcase
		end else if (mem_capt) begin
			nxt_seq = SEQ_LOADED;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			seq_ff     <= SEQ_IDLE;
			ee_mode_ff <= '0;
			ee_addr_ff <= '0;
			ee_data_ff <= '0;
		end else begin
			seq_ff <= nxt_seq;
			if (wr_nvm)
				ee_mode_ff <= wd[6:2];
			if (mem_capt) begin
				ee_addr_ff <= mem_addr_i;
				ee_data_ff <= mem_wdata_i;
			end
		end
	end

	// Erase and program act at once when the voltage turns on; the array is a behavioural cell model
	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (op_go & ~lat_set & ~prot_ff[blk_of(16'(i))]) begin
				if (erase_op) begin
					if (ee_mode_ff[POS_BYTE] ? (16'(i) == lat_off) :
					    ee_mode_ff[POS_ROW] ? (16'(i) >> 4 == lat_off >> 4) : 1'b1)
						mem_ff[i] <= ERASED_BYTE;
				end else if (16'(i) == lat_off) begin
					mem_ff[i] <= mem_ff[i] & ee_data_ff;
				end
			end
		end
	end

	// Setup word is nonvolatile: reset does not restore it
	always_ff @(posedge clk_sys_i) begin
		if (op_go & lat_set)
			setup_ff <= erase_op ? ERASED_BYTE : (setup_ff & ee_data_ff);
	end

	// ****************************************************************
	// Erasable read port
	// ****************************************************************
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ee_rdata_o <= '0;
			ee_hit_o   <= 1'b0;
		end else begin
			ee_hit_o   <= mem_re_i & in_array & (seq_ff == SEQ_IDLE);
			ee_rdata_o <= mem_ff[mem_off[AW-1:0]];
		end
	end

	// ****************************************************************
	// Protect register
	// ****************************************************************
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prot_ff    <= PROT_RESET;
			win_cnt_ff <= '0;
		end else begin
			if (win_open)
				win_cnt_ff <= win_cnt_ff + 7'd1;
			if (wr_prot)
				prot_ff <= (special | win_open) ? (wd & PROT_MASK) : (prot_ff | (wd & PROT_MASK));
		end
	end

	// ****************************************************************
	// One-time memory control
	// ****************************************************************
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			otp_latch_ff <= 1'b0;
			otp_volt_ff  <= 1'b0;
			xcols_ff     <= 1'b0;
			xrows_ff     <= 1'b0;
			stress_ff    <= '0;
		end else if (wr_otp) begin
			if (~otp_volt_ff)
				otp_latch_ff <= wd[POS_OTP_LATCH];
			if (otp_latch_ff)
				otp_volt_ff <= wd[POS_OTP_VOLT];
			if (special) begin
				xcols_ff  <= wd[POS_EXTRA_COL];
				xrows_ff  <= wd[POS_EXTRA_ROW];
				stress_ff <= wd[POS_STRESS_LO+:2];
			end
		end
	end

	wire logic        xcols_on = xcols_ff & special;
	wire logic        xrows_on = xrows_ff & special;
	wire logic [13:0] otp_map  = xcols_on ? {mem_addr_i[13:5], 5'h00} :
	                             xrows_on ? {6'h00, mem_addr_i[7:0]} : mem_addr_i[13:0];

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			otp_latched_addr_o <= '0;
			otp_latched_data_o <= '0;
			otp_array_addr_o   <= '0;
		end else begin
			otp_array_addr_o <= otp_map;
			if (mem_we_i & otp_latch_ff & ~otp_volt_ff) begin
				otp_latched_addr_o <= mem_addr_i;
				otp_latched_data_o <= mem_wdata_i;
			end
		end
	end

	assign otp_read_enable_o = ~otp_latch_ff;
	assign otp_voltage_o     = otp_volt_ff;
	assign otp_stress_o      = special ? stress_ff : 2'b00;
	assign ee_voltage_o      = (seq_ff == SEQ_HIGH_VOLT);

	// ****************************************************************
	// Pump clock
	// ****************************************************************
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			pump_sel_ff <= 1'b0;
		else if (wr_option)
			pump_sel_ff <= wd[POS_PUMP_SEL];
	end

	// Plain mux: switching while the pump runs may glitch, so change it with voltage off
	assign pump_clk_o = pump_sel_ff ? rc_osc_clk_i : clk_sys_i;

	// ****************************************************************
	// Read mux and acknowledge
	// ****************************************************************
	wire logic [7:0] rd_nvm   = {1'b0, ee_mode_ff, seq_ff != SEQ_IDLE, seq_ff == SEQ_HIGH_VOLT};
	wire logic [7:0] rd_otp   = {1'b0, 1'b0, otp_latch_ff, xcols_on, xrows_on, otp_stress_o, otp_volt_ff};
	wire logic [7:0] rd_prot  = prot_ff & PROT_MASK;
	wire logic [7:0] rd_stat  = {3'h0, win_open, special, ee_voltage_o, seq_ff};
	wire logic [7:0] rd_sel   = (wb_adr_i == ADR_NVM_CTRL)   ? rd_nvm :
	                            (wb_adr_i == ADR_OTP_CTRL)   ? rd_otp :
	                            (wb_adr_i == ADR_BLOCK_PROT) ? rd_prot :
	                            (wb_adr_i == ADR_SETUP_WORD) ? setup_ff :
	                            (wb_adr_i == ADR_OPTION)     ? {7'h00, pump_sel_ff} :
	                            (wb_adr_i == ADR_STATUS)     ? rd_stat : 8'h00;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_ff  <= 1'b0;
			rdat_ff <= '0;
		end else begin
			ack_ff  <= req;
			rdat_ff <= req ? {24'h000000, rd_sel} : 32'h00000000;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_both_bits_refused: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(wr_nvm && seq_ff == SEQ_IDLE && wr_l && wr_p) |=> (seq_ff == SEQ_IDLE))
		else $error("both bits set from idle");
	a_volt_needs_load: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		$rose(ee_voltage_o) |-> $past(seq_ff) == SEQ_LOADED)
		else $error("voltage without loaded write");
	a_otp_latch_held: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(wr_otp && otp_volt_ff) |=> $stable(otp_latch_ff))
		else $error("latch select changed under voltage");
	a_otp_volt_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(wr_otp && !otp_latch_ff) |=> $stable(otp_volt_ff))
		else $error("voltage enable written without latch");
	a_prot_late_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(wr_prot && !special && !win_open) |=> ((prot_ff & $past(prot_ff)) == $past(prot_ff)))
		else $error("protect bit cleared after window");
	a_prot_set_one: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		wr_prot |=> ((prot_ff & $past(wd) & PROT_MASK) == ($past(wd) & PROT_MASK)))
		else $error("protect write of one lost");
	a_no_read_latched: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(seq_ff != SEQ_IDLE) |=> !ee_hit_o)
		else $error("array read while latched");
	a_otp_bit6_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(wb_ack_o && $past(wb_adr_i) == ADR_OTP_CTRL) |-> (wb_dat_o[6] == 1'b0))
		else $error("bit 6 read as one");
	a_prot_hi_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(wb_ack_o && $past(wb_adr_i) == ADR_BLOCK_PROT) |-> (wb_dat_o[7:5] == 3'b000))
		else $error("protect upper bits set");
	a_ack_one_cycle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not single cycle");
	// Invariants that hold whatever software writes, save a_otp_volt_latched: one write can set voltage and clear latch select
	a_columns_hidden: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(wb_ack_o && $past(wb_adr_i) == ADR_OTP_CTRL && !$past(special)) |-> (wb_dat_o[4:1] == 4'h0))
		else $error("special bits read in normal mode");
	a_otp_volt_latched: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		otp_volt_ff |-> otp_latch_ff)
		else $error("voltage on without latch select");
	a_capture_held: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		otp_volt_ff |=> ($stable(otp_latched_addr_o) && $stable(otp_latched_data_o)))
		else $error("latched word changed under voltage");
	a_setup_guarded: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		prot_ff[POS_SETUP_PROT] |=> $stable(setup_ff))
		else $error("protected setup word changed");
	a_first_block_guarded: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		prot_ff[0] |=> $stable(mem_ff[0]))
		else $error("protected block changed");
	a_array_hidden: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!setup_ff[POS_MEM_VISIBLE] |=> !ee_hit_o)
		else $error("hidden array answered a read");

	c_program_done: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		op_go && !erase_op);
	c_erase_done: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		op_go && erase_op);
	c_blocked_try: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(seq_ff == SEQ_LOADED) && (nxt_seq == SEQ_HIGH_VOLT) && lat_blocked);
	c_setup_program: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		op_go && lat_set);
	c_otp_voltage: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		$rose(otp_voltage_o));

endmodule

/* File: nppc_core_bus.sv */
// Processor core memory port model, the far side of the memory interface
`timescale 1ns/1ns
module nppc_core_bus (
	input  wire logic        clk_sys_i,
	output logic             mem_we_o,
	output logic             mem_re_o,
	output logic [15:0]      mem_addr_o,
	output logic [7:0]       mem_wdata_o
);
	// ****************************************************************
	// One-cycle read or write strobes, launched just after an edge
	// ****************************************************************
	initial begin
		mem_we_o = 1'b0;
		mem_re_o = 1'b0;
		mem_addr_o = 16'h0000;
		mem_wdata_o = 8'h00;
	end
	task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		mem_we_o <= we;
		mem_re_o <= !we;
		mem_addr_o <= a;
		mem_wdata_o <= d;
		@(posedge clk_sys_i);
		mem_we_o <= 1'b0;
		mem_re_o <= 1'b0;
		// Idle data bus must not look like the last byte
		mem_wdata_o <= ~d;
	endtask
endmodule

/* File: nppc_pkg.sv */
// Constants, field layouts and types of the nonvolatile programming and protect control
package nppc_pkg;

	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [15:0] IDX_NVM_CTRL   = 16'h103b;
	localparam logic [15:0] IDX_OTP_CTRL   = 16'h1036;
	localparam logic [15:0] IDX_BLOCK_PROT = 16'h1035;
	localparam logic [15:0] IDX_SETUP_WORD = 16'h103f;
	localparam logic [15:0] IDX_OPTION     = 16'h1039;
	localparam logic [15:0] IDX_STATUS     = 16'h1030;
	localparam int          WB_ADR_W       = 18;
	localparam logic [WB_ADR_W-1:0] ADR_NVM_CTRL   = {IDX_NVM_CTRL, 2'b00};
	localparam logic [WB_ADR_W-1:0] ADR_OTP_CTRL   = {IDX_OTP_CTRL, 2'b00};
	localparam logic [WB_ADR_W-1:0] ADR_BLOCK_PROT = {IDX_BLOCK_PROT, 2'b00};
	localparam logic [WB_ADR_W-1:0] ADR_SETUP_WORD = {IDX_SETUP_WORD, 2'b00};
	localparam logic [WB_ADR_W-1:0] ADR_OPTION     = {IDX_OPTION, 2'b00};
	localparam logic [WB_ADR_W-1:0] ADR_STATUS     = {IDX_STATUS, 2'b00};

	// ****************************************************************
	// Erasable memory programming control fields
	// ****************************************************************
	localparam int POS_ODD   = 6;
	localparam int POS_EVEN  = 5;
	localparam int POS_BYTE  = 4;
	localparam int POS_ROW   = 3;
	localparam int POS_ERASE = 2;
	localparam int POS_LATCH = 1;
	localparam int POS_VOLT  = 0;

	// ****************************************************************
	// One-time memory programming control fields
	// ****************************************************************
	localparam int POS_OTP_LATCH = 5;
	localparam int POS_EXTRA_COL = 4;
	localparam int POS_EXTRA_ROW = 3;
	localparam int POS_STRESS_LO = 1;
	localparam int POS_OTP_VOLT  = 0;

	// ****************************************************************
	// Protect, setup word and option fields, reset values
	// ****************************************************************
	localparam int        POS_SETUP_PROT  = 4;
	localparam logic [7:0] PROT_RESET     = 8'h1f;
	localparam logic [7:0] PROT_MASK      = 8'h1f;
	localparam int        POS_MEM_VISIBLE = 0;
	localparam int        POS_BASE_LO     = 4;
	localparam int        POS_PUMP_SEL    = 0;
	localparam logic [7:0] ERASED_BYTE    = 8'hff;

	// ****************************************************************
	// Memory map and timing
	// ****************************************************************
	localparam logic [15:0] MEM_SETUP_ADDR  = 16'h103f;
	localparam logic [15:0] SMALL_BASE      = 16'hb600;
	localparam logic [15:0] BLK1_START      = 16'h0020;
	localparam logic [15:0] BLK2_START      = 16'h0060;
	localparam logic [15:0] BLK3_START      = 16'h00e0;
	localparam int          SMALL_DEPTH     = 512;
	localparam int          LARGE_DEPTH     = 2048;
	localparam logic [11:0] LARGE_OFFSET    = 12'h800;
	localparam int          PROT_WINDOW_CYC = 64;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_OPEN,
		SEQ_LOADED,
		SEQ_HIGH_VOLT
	} nppc_seq_type;

endpackage

/* File: nvm_program_protect_control_test.sv */
// Self-checking bench of the programming and protect control
`timescale 1ns/1ns
module nvm_program_protect_control_test;
	import nppc_pkg::*;
	typedef struct {logic we; logic [WB_ADR_W-1:0] adr; logic [7:0] dat;} nppc_row_type;
	logic                clk_sys_i;
	logic                sys_rst_i;
	logic                rc_osc_clk_i;
	logic                special_mode_i;
	logic                wb_cyc_i;
	logic                wb_stb_i;
	logic                wb_we_i;
	logic [WB_ADR_W-1:0] wb_adr_i;
	logic [3:0]          wb_sel_i;
	logic [31:0]         wb_dat_i;
	logic [31:0]         wb_dat_o;
	logic                wb_ack_o;
	logic                mem_we_i;
	logic                mem_re_i;
	logic [15:0]         mem_addr_i;
	logic [7:0]          mem_wdata_i;
	logic [7:0]          ee_rdata_o;
	logic                ee_hit_o;
	logic [15:0]         otp_latched_addr_o;
	logic [7:0]          otp_latched_data_o;
	logic [13:0]         otp_array_addr_o;
	logic                otp_read_enable_o;
	logic                otp_voltage_o;
	logic [1:0]          otp_stress_o;
	logic                ee_voltage_o;
	logic                pump_clk_o;
	logic [31:0]         rd;
	int                  failures;
	int                  checks;
	// Reads carry the expected byte in dat; rows run inside the protect window
	nppc_row_type rows [12] = '{'{1'b0, ADR_NVM_CTRL, 8'h00}, '{1'b0, ADR_OTP_CTRL, 8'h00},
		'{1'b0, ADR_BLOCK_PROT, 8'h1f}, '{1'b0, ADR_SETUP_WORD, 8'h01}, '{1'b0, 18'h00000, 8'h00},
		'{1'b1, ADR_BLOCK_PROT, 8'h00}, '{1'b0, ADR_BLOCK_PROT, 8'h00}, '{1'b1, ADR_BLOCK_PROT, 8'hff},
		'{1'b0, ADR_BLOCK_PROT, 8'h1f}, '{1'b1, ADR_OTP_CTRL, 8'h7e}, '{1'b0, ADR_OTP_CTRL, 8'h20},
		'{1'b1, ADR_OTP_CTRL, 8'h00}};

	nppc_core u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .special_mode_i(special_mode_i), .mem_we_i(mem_we_i), .mem_re_i(mem_re_i),
		.mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i), .ee_rdata_o(ee_rdata_o), .ee_hit_o(ee_hit_o),
		.otp_latched_addr_o(otp_latched_addr_o), .otp_latched_data_o(otp_latched_data_o),
		.otp_array_addr_o(otp_array_addr_o), .otp_read_enable_o(otp_read_enable_o),
		.otp_voltage_o(otp_voltage_o), .otp_stress_o(otp_stress_o), .ee_voltage_o(ee_voltage_o),
		.rc_osc_clk_i(rc_osc_clk_i), .pump_clk_o(pump_clk_o));
	nppc_core_bus u_bus (.clk_sys_i(clk_sys_i), .mem_we_o(mem_we_i), .mem_re_o(mem_re_i),
		.mem_addr_o(mem_addr_i), .mem_wdata_o(mem_wdata_i));

	// ****************************************************************
	// Clocks; the oscillator edges sit on odd nanoseconds to avoid races
	// ****************************************************************
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		rc_osc_clk_i = 1'b0;
		#1;
		forever #14 rc_osc_clk_i = ~rc_osc_clk_i;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [WB_ADR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		cmp("ack latency", 32'd2, n);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rr(input logic [WB_ADR_W-1:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		cmp("register", {24'h000000, e}, rd);
	endtask
	task automatic mr(input logic [15:0] a, input logic [7:0] e, input logic h);
		u_bus.access(1'b0, a, 8'h00);
		#1 cmp("hit", {31'h0, h}, {31'h0, ee_hit_o});
		if (h) cmp("array byte", {24'h000000, e}, {24'h000000, ee_rdata_o});
	endtask
	task automatic pe(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
		wb(1'b1, ADR_NVM_CTRL, c);
		mr(a, 8'h00, 1'b0);
		u_bus.access(1'b1, a, d);
		wb(1'b1, ADR_NVM_CTRL, c | 8'h01);
		#1 cmp("ee voltage", 32'h1, {31'h0, ee_voltage_o});
		wb(1'b1, ADR_NVM_CTRL, 8'h00);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		failures = 0;
		checks = 0;
		sys_rst_i = 1'b1;
		special_mode_i = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = '0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h00000000;
		repeat (6) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].adr, rows[i].dat);
			if (!rows[i].we) cmp("row read", {24'h000000, rows[i].dat}, rd);
		end
		// Window closed: normal mode clear refused, special mode clear accepted
		repeat (64) @(posedge clk_sys_i);
		wb(1'b1, ADR_BLOCK_PROT, 8'h00);
		rr(ADR_BLOCK_PROT, 8'h1f);
		special_mode_i <= 1'b1;
		wb(1'b1, ADR_BLOCK_PROT, 8'h01);
		wb(1'b1, ADR_BLOCK_PROT, 8'h00);
		rr(ADR_BLOCK_PROT, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, ADR_OTP_CTRL, 8'(s << 1) | 8'h18);
			rr(ADR_OTP_CTRL, 8'(s << 1) | 8'h18);
			cmp("stress", s, {30'h0, otp_stress_o});
		end
		wb(1'b1, ADR_OTP_CTRL, 8'h10);
		u_bus.access(1'b0, 16'h3fff, 8'h00);
		#1 cmp("column addr", 32'h3fe0, {18'h0, otp_array_addr_o});
		wb(1'b1, ADR_OTP_CTRL, 8'h08);
		u_bus.access(1'b0, 16'h3fff, 8'h00);
		#1 cmp("row addr", 32'h00ff, {18'h0, otp_array_addr_o});
		wb(1'b1, ADR_OTP_CTRL, 8'h01);
		rr(ADR_OTP_CTRL, 8'h00);
		wb(1'b1, ADR_OTP_CTRL, 8'h20);
		#1 cmp("otp read enable", 32'h0, {31'h0, otp_read_enable_o});
		u_bus.access(1'b1, 16'hd123, 8'h5a);
		#1 cmp("otp addr", 32'hd123, {16'h0, otp_latched_addr_o});
		cmp("otp data", 32'h5a, {24'h0, otp_latched_data_o});
		wb(1'b1, ADR_OTP_CTRL, 8'h21);
		#1 cmp("otp voltage", 32'h1, {31'h0, otp_voltage_o});
		wb(1'b1, ADR_OTP_CTRL, 8'h00);
		rr(ADR_OTP_CTRL, 8'h20);
		wb(1'b1, ADR_OTP_CTRL, 8'h00);
		rr(ADR_OTP_CTRL, 8'h00);
		// Erasable array: program, protect boundary, erase kinds
		mr(16'hb600, 8'hff, 1'b1);
		wb(1'b1, ADR_NVM_CTRL, 8'h03);
		rr(ADR_NVM_CTRL, 8'h00);
		pe(8'h02, 16'hb600, 8'ha5);
		mr(16'hb600, 8'ha5, 1'b1);
		pe(8'h02, 16'hb600, 8'h0f);
		mr(16'hb600, 8'h05, 1'b1);
		wb(1'b1, ADR_BLOCK_PROT, 8'h01);
		pe(8'h02, 16'hb61f, 8'h00);
		mr(16'hb61f, 8'hff, 1'b1);
		pe(8'h02, 16'hb620, 8'h00);
		mr(16'hb620, 8'h00, 1'b1);
		pe(8'h06, 16'hb620, 8'h00);
		mr(16'hb600, 8'h05, 1'b1);
		mr(16'hb620, 8'hff, 1'b1);
		wb(1'b1, ADR_BLOCK_PROT, 8'h00);
		pe(8'h16, 16'hb600, 8'h00);
		mr(16'hb600, 8'hff, 1'b1);
		// Setup word guarded, then cleared to hide the array
		wb(1'b1, ADR_BLOCK_PROT, 8'h10);
		pe(8'h02, MEM_SETUP_ADDR, 8'h00);
		rr(ADR_SETUP_WORD, 8'h01);
		wb(1'b1, ADR_BLOCK_PROT, 8'h00);
		pe(8'h02, MEM_SETUP_ADDR, 8'hfe);
		rr(ADR_SETUP_WORD, 8'h00);
		mr(16'hb600, 8'hff, 1'b0);
		wb(1'b1, ADR_OPTION, 8'h01);
		repeat (16) begin
			#2 cmp("pump clock", {31'h0, rc_osc_clk_i}, {31'h0, pump_clk_o});
		end
		wb(1'b1, ADR_OPTION, 8'h00);
		#2 cmp("pump clock", {31'h0, clk_sys_i}, {31'h0, pump_clk_o});
		tally_and_finish();
	end

	// Cuts a hang short well past the expected few hundred cycles
	initial begin
		#200000;
		failures++;
		tally_and_finish();
	end
endmodule
